// ==== src/tcc_pkg.sv ====
// Constants, register map and state types for the timer channel capture/compare block
// *****************************************************************************
// *****************************************************************************
package tcc_pkg;

  // *****************************************************************************
  // Bus and register map
  // *****************************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned VAL_W = 16;
  localparam int unsigned NUM_CH = 2;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTL [NUM_CH] = '{8'h45, 8'h48};
  localparam logic [7:0] IDX_HI [NUM_CH] = '{8'h46, 8'h49};
  localparam logic [7:0] IDX_LO [NUM_CH] = '{8'h47, 8'h4A};
  localparam logic [1:0] WORD_PAD = 2'h0;

  // *****************************************************************************
  // Field codes
  // *****************************************************************************
  localparam int unsigned CTL_FLAG_BIT = 7;
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_RISE_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_FALL_CLEAR = 2'h2;
  localparam logic [1:0] ELS_BOTH_SET = 2'h3;

  // Channel control/status byte, bit 7 first
  typedef struct packed {
    logic flag;
    logic irq_en;
    logic buf_sel;
    logic mode_a;
    logic [1:0] els;
    logic tov;
    logic full_duty;
  } tcc_ctl_t;

  // Whole block state, registered as one word
  typedef struct packed {
    logic rdy;
    logic slverr;
    logic [DATA_W-1:0] rdata;
    tcc_ctl_t [NUM_CH-1:0] ctl;
    logic [NUM_CH-1:0][VAL_W-1:0] val;
    logic [NUM_CH-1:0] armed;
    logic [NUM_CH-1:0] cap_lock;
    logic [NUM_CH-1:0] cmp_lock;
    logic [NUM_CH-1:0] level;
    logic [NUM_CH-1:0] pin_prev;
    logic [NUM_CH-1:0] full_act;
    logic [NUM_CH-1:0] oe;
    logic [NUM_CH-1:0] irq;
    logic buf_act;
    logic buf_pend;
  } tcc_state_t;

  // Level resets high since bit A resets to zero
  localparam tcc_state_t STATE_RESET = '{level: 2'h3, default: '0};

endpackage : tcc_pkg

// ==== src/tcc_timer_channel.sv ====
// Two-channel capture/compare/PWM logic with APB register access
`timescale 1ns/10ps
module tcc_timer_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] counter_value,
  input wire logic counter_wrap,
  input wire logic counter_halt,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic [1:0] chan_irq
);

  // *****************************************************************************
  // Helpers
  // *****************************************************************************
  // Word address match for a register index
  function automatic logic at_idx(input logic [11:0] a, input logic [7:0] idx);
    return a == {tcc_pkg::WORD_PAD, idx, tcc_pkg::WORD_PAD};
  endfunction : at_idx

  // Any register of the map
  function automatic logic is_mapped(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < tcc_pkg::NUM_CH; i++) begin
      hit = hit | at_idx(a, tcc_pkg::IDX_CTL[i]) | at_idx(a, tcc_pkg::IDX_HI[i]);
      hit = hit | at_idx(a, tcc_pkg::IDX_LO[i]);
    end
    return hit;
  endfunction : is_mapped

  // Active edge per edge/level code
  function automatic logic edge_hit(input logic [1:0] els, input logic prev, input logic now);
    logic rise;
    logic fall;
    rise = !prev && now;
    fall = prev && !now;
    unique case (els)
      tcc_pkg::ELS_RISE_TOGGLE: return rise;
      tcc_pkg::ELS_FALL_CLEAR: return fall;
      tcc_pkg::ELS_BOTH_SET: return rise | fall;
      tcc_pkg::ELS_OFF: return 1'b0;
    endcase
  endfunction : edge_hit

  // Pin level after a compare match
  function automatic logic cmp_level(input logic [1:0] els, input logic lvl);
    unique case (els)
      tcc_pkg::ELS_RISE_TOGGLE: return !lvl;
      tcc_pkg::ELS_FALL_CLEAR: return 1'b0;
      tcc_pkg::ELS_BOTH_SET: return 1'b1;
      tcc_pkg::ELS_OFF: return lvl;
    endcase
  endfunction : cmp_level

  // *****************************************************************************
  // State
  // *****************************************************************************
  tcc_pkg::tcc_state_t s;
  tcc_pkg::tcc_state_t next_s;
  logic [1:0] cap_ev;
  logic [1:0] cmp_ev;
  logic [1:0] out_mode;
  logic [1:0] cap_mode;

  // *****************************************************************************
  // Next-state logic
  // *****************************************************************************
  // Bus side effects first, then channel events, so a hardware set beats a clear
  always_comb begin
    tcc_pkg::tcc_ctl_t wc;
    tcc_pkg::tcc_ctl_t c;
    logic acc;
    logic wr;
    logic rd;
    logic ch1_on;
    logic en;
    logic bufm;
    logic lk;
    logic ev;
    logic [15:0] cmpv;
    next_s = s;
    wc = tcc_pkg::tcc_ctl_t'(pwdata[7:0]);
    c = s.ctl[0];
    en = 1'b0;
    bufm = 1'b0;
    lk = 1'b0;
    ev = 1'b0;
    cmpv = '0;
    cap_ev = '0;
    cmp_ev = '0;
    out_mode = '0;
    cap_mode = '0;
    // Access completes at the edge where pready is seen high
    acc = psel && penable && s.rdy;
    wr = acc && pwrite && pstrb[0];
    rd = acc && !pwrite;
    ch1_on = !s.ctl[0].buf_sel;

    // No wait state: answer prepared in the setup cycle, so pready is a flop
    next_s.rdy = 1'b0;
    next_s.slverr = 1'b0;
    if (psel && !penable && !s.rdy) begin
      next_s.rdy = 1'b1;
      next_s.slverr = !is_mapped(paddr);
      next_s.rdata = '0;
      for (int i = 0; i < tcc_pkg::NUM_CH; i++) begin
        if (at_idx(paddr, tcc_pkg::IDX_CTL[i]) && (i == 0 || ch1_on)) begin
          next_s.rdata[7:0] = s.ctl[i];
        end
        if (at_idx(paddr, tcc_pkg::IDX_HI[i])) begin
          next_s.rdata[7:0] = s.val[i][15:8];
        end
        if (at_idx(paddr, tcc_pkg::IDX_LO[i])) begin
          next_s.rdata[7:0] = s.val[i][7:0];
        end
      end
    end

    // Register writes and read side effects
    for (int i = 0; i < tcc_pkg::NUM_CH; i++) begin
      c = s.ctl[i];
      bufm = (i == 0) && c.buf_sel;
      if (wr && at_idx(paddr, tcc_pkg::IDX_CTL[i]) && (i == 0 || ch1_on)) begin
        next_s.ctl[i] = wc;
        // A one written to the flag keeps it; a zero clears only when armed
        next_s.ctl[i].flag = c.flag && !(s.armed[i] && !wc.flag);
        if (i == 1) begin
          next_s.ctl[i].buf_sel = 1'b0;
        end
        next_s.armed[i] = 1'b0;
      end
      // Arm only if the value returned to software showed the flag set
      if (rd && at_idx(paddr, tcc_pkg::IDX_CTL[i]) && s.rdata[tcc_pkg::CTL_FLAG_BIT]) begin
        next_s.armed[i] = 1'b1;
      end
      if (wr && at_idx(paddr, tcc_pkg::IDX_HI[i])) begin
        next_s.val[i][15:8] = pwdata[7:0];
        if (bufm || c.mode_a) begin
          next_s.cmp_lock[i] = 1'b1;
        end
      end
      if (wr && at_idx(paddr, tcc_pkg::IDX_LO[i])) begin
        next_s.val[i][7:0] = pwdata[7:0];
        next_s.cmp_lock[i] = 1'b0;
        next_s.buf_pend = (i == 1);
      end
      if (rd && at_idx(paddr, tcc_pkg::IDX_HI[i]) && !bufm && !c.mode_a) begin
        next_s.cap_lock[i] = 1'b1;
      end
      if (rd && at_idx(paddr, tcc_pkg::IDX_LO[i])) begin
        next_s.cap_lock[i] = 1'b0;
      end
    end

    // Channel capture, compare and pin level
    for (int i = 0; i < tcc_pkg::NUM_CH; i++) begin
      c = s.ctl[i];
      en = (i == 0) || ch1_on;
      bufm = (i == 0) && c.buf_sel;
      cap_mode[i] = en && !bufm && !c.mode_a && (c.els != tcc_pkg::ELS_OFF);
      out_mode[i] = en && (bufm || c.mode_a) && (c.els != tcc_pkg::ELS_OFF);
      next_s.pin_prev[i] = pin_in[i];
      // Buffered channel 0 compares against the active one of the two values
      cmpv = bufm ? s.val[s.buf_act] : s.val[i];
      lk = bufm ? s.cmp_lock[s.buf_act] : s.cmp_lock[i];
      cap_ev[i] = cap_mode[i] && !counter_halt && !s.cap_lock[i]
                  && edge_hit(c.els, s.pin_prev[i], pin_in[i]);
      cmp_ev[i] = out_mode[i] && !lk && (counter_value == cmpv);
      ev = cap_ev[i] || cmp_ev[i];
      if (cap_ev[i]) begin
        next_s.val[i] = counter_value;
      end
      if (ev) begin
        // Set wins over a clear in the same cycle and voids a pending clear
        next_s.ctl[i].flag = 1'b1;
        next_s.armed[i] = 1'b0;
      end
      if (!en || c.els == tcc_pkg::ELS_OFF) begin
        next_s.level[i] = !c.mode_a;
      end else if (out_mode[i]) begin
        if (c.tov && counter_wrap) begin
          // Full duty with the clear or set code: hold the active level instead of toggling at the wrap
          if (s.full_act[i] && c.els != tcc_pkg::ELS_RISE_TOGGLE) begin
            next_s.level[i] = (c.els == tcc_pkg::ELS_FALL_CLEAR);
          end else begin
            next_s.level[i] = !s.level[i];
          end
        end else if (cmp_ev[i] && !(c.tov && s.full_act[i])) begin
          next_s.level[i] = cmp_level(c.els, s.level[i]);
        end
      end
      // Full-duty setting is taken only at a period boundary
      if (counter_wrap) begin
        next_s.full_act[i] = c.tov && c.full_duty;
      end
      next_s.oe[i] = out_mode[i];
      next_s.irq[i] = en && next_s.ctl[i].flag && next_s.ctl[i].irq_en;
    end

    // Buffered value swap happens only on the wrap boundary
    if (counter_wrap && s.ctl[0].buf_sel) begin
      next_s.buf_act = s.buf_pend;
    end
  end

  // *****************************************************************************
  // State register
  // *****************************************************************************
  // Reset clears all control fields and both flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= tcc_pkg::STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign prdata = s.rdata;
  assign pready = s.rdy;
  assign pslverr = s.slverr;
  assign pin_out = s.level;
  assign pin_oe = s.oe;
  assign chan_irq = s.irq;

  // *****************************************************************************
  // Assertions
  // *****************************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_capture_sets_flag: assert property (cap_ev[0] |=> s.ctl[0].flag)
    else $error("capture did not set channel 0 flag");
  a_compare_sets_flag: assert property (cmp_ev[1] |=> s.ctl[1].flag)
    else $error("compare did not set channel 1 flag");
  a_flag_clear_armed: assert property ($fell(s.ctl[0].flag) |-> $past(s.armed[0]))
    else $error("flag cleared without read of set flag");
  a_one_write_keeps: assert property (psel && penable && pready && pwrite && pstrb[0]
    && at_idx(paddr, tcc_pkg::IDX_CTL[0]) && pwdata[7] && s.ctl[0].flag
    |=> s.ctl[0].flag)
    else $error("writing one changed the flag");
  a_irq_gated: assert property (!s.ctl[0].irq_en |-> !chan_irq[0])
    else $error("interrupt raised while disabled");
  a_ch1_released: assert property (s.ctl[0].buf_sel |=> !pin_oe[1] && !cap_ev[1])
    else $error("channel 1 active in buffered mode");
  a_off_no_drive: assert property (s.ctl[0].els == tcc_pkg::ELS_OFF
    |=> !pin_oe[0] && pin_out[0] == !$past(s.ctl[0].mode_a))
    else $error("pin driven or wrong preset level");
  a_capture_copy: assert property (cap_ev[1] |=> s.val[1] == $past(counter_value))
    else $error("capture value not stored");
  a_halt_blocks: assert property (counter_halt |-> cap_ev == 2'h0)
    else $error("capture while counter halted");
  a_read_lock: assert property (s.cap_lock[0] |-> !cap_ev[0])
    else $error("capture during high byte lock");
  a_write_lock: assert property (s.cmp_lock[1] && !s.ctl[0].buf_sel |-> !cmp_ev[1])
    else $error("compare during high byte lock");
  a_wrap_toggle: assert property (out_mode[0] && s.ctl[0].tov && counter_wrap
    && !s.full_act[0] |=> pin_out[0] != $past(pin_out[0]))
    else $error("no toggle on counter wrap");

  // Interrupt line mirrors flag and enable on the always-enabled channel
  a_irq_follows: assert property (chan_irq[0] == (s.ctl[0].flag && s.ctl[0].irq_en))
    else $error("channel 0 interrupt does not follow flag and enable");

  // Channel 1 flag falls only after a read that showed it set
  a_flag_clear_ch1: assert property ($fell(s.ctl[1].flag) |-> $past(s.armed[1]))
    else $error("channel 1 flag cleared without read of set flag");
  // A hardware event always leaves the flag set, whatever the bus did
  a_event_wins: assert property ((cap_ev[0] || cmp_ev[0]) |=> s.ctl[0].flag)
    else $error("bus clear beat a channel 0 event");

  // Buffered mode freezes channel 1 control and silences its interrupt
  a_ch1_frozen: assert property (s.ctl[0].buf_sel |=> $stable(s.ctl[1]))
    else $error("channel 1 control changed in buffered mode");
  a_ch1_irq_off: assert property (s.ctl[0].buf_sel |=> !chan_irq[1])
    else $error("channel 1 interrupt in buffered mode");

  // Mode bits decide whether an event is a capture or a compare
  a_capture_mode: assert property (cap_ev[0] |-> !s.ctl[0].mode_a && !s.ctl[0].buf_sel)
    else $error("capture outside capture mode");
  a_compare_mode: assert property (cmp_ev[0] |-> s.ctl[0].mode_a || s.ctl[0].buf_sel)
    else $error("compare outside compare mode");

  // Single-edge codes ignore the opposite edge
  a_rise_only: assert property (
    cap_ev[0] && s.ctl[0].els == tcc_pkg::ELS_RISE_TOGGLE |-> pin_in[0] && !s.pin_prev[0])
    else $error("capture on a falling edge with rising-only code");
  a_fall_only: assert property (
    cap_ev[0] && s.ctl[0].els == tcc_pkg::ELS_FALL_CLEAR |-> !pin_in[0] && s.pin_prev[0])
    else $error("capture on a rising edge with falling-only code");

  // Clear and set codes drive a fixed level on a plain compare match
  a_clear_action: assert property (
    cmp_ev[0] && s.ctl[0].els == tcc_pkg::ELS_FALL_CLEAR && !s.ctl[0].tov |=> !pin_out[0])
    else $error("clear-on-compare left the pin high");
  a_set_action: assert property (
    cmp_ev[0] && s.ctl[0].els == tcc_pkg::ELS_BOTH_SET && !s.ctl[0].tov |=> pin_out[0])
    else $error("set-on-compare left the pin low");

  // The pin is only driven with a nonzero edge/level field
  a_oe_needs_field: assert property (
    pin_oe[0] |-> $past(s.ctl[0].els) != tcc_pkg::ELS_OFF)
    else $error("channel 0 drives its pin with the field at zero");

  // Wrap wins over a coincident match: exactly one toggle, never two
  a_wrap_beats_match: assert property (
    out_mode[0] && s.ctl[0].tov && counter_wrap && cmp_ev[0] && !s.full_act[0]
    |=> pin_out[0] != $past(pin_out[0]))
    else $error("coincident wrap and match did not toggle once");

  // Full duty is latched only at a period boundary
  a_full_latch: assert property (
    counter_wrap |=> s.full_act[0] == $past(s.ctl[0].tov && s.ctl[0].full_duty))
    else $error("full duty not latched at the wrap");
  a_full_steady: assert property (
    !counter_wrap |=> $stable(s.full_act[0]))
    else $error("full duty changed inside a period");

  // Buffered value selection moves only at a wrap
  a_buffer_hold: assert property (
    !(counter_wrap && s.ctl[0].buf_sel) |=> $stable(s.buf_act))
    else $error("buffered value switched between wraps");

  // Coherent 16-bit access: lock on the high byte, release on the low byte
  a_hi_read_locks: assert property (
    psel && penable && pready && !pwrite && at_idx(paddr, tcc_pkg::IDX_HI[0])
    && !s.ctl[0].mode_a && !s.ctl[0].buf_sel |=> s.cap_lock[0])
    else $error("high byte read did not block captures");
  a_lo_read_frees: assert property (
    psel && penable && pready && !pwrite && at_idx(paddr, tcc_pkg::IDX_LO[0])
    |=> !s.cap_lock[0])
    else $error("low byte read did not release captures");
  a_hi_write_locks: assert property (
    psel && penable && pready && pwrite && pstrb[0] && at_idx(paddr, tcc_pkg::IDX_HI[1])
    && s.ctl[1].mode_a |=> s.cmp_lock[1])
    else $error("high byte write did not block compares");
  a_lo_write_frees: assert property (
    psel && penable && pready && pwrite && pstrb[0] && at_idx(paddr, tcc_pkg::IDX_LO[1])
    |=> !s.cmp_lock[1])
    else $error("low byte write did not release compares");

  // A captured value is the counter seen in the capture cycle
  a_capture_copy0: assert property (
    cap_ev[0] |=> s.val[0] == $past(counter_value))
    else $error("channel 0 capture value not stored");

  // Compare match needs the counter equal to the channel value
  a_match_value: assert property (
    cmp_ev[1] |-> counter_value == s.val[1])
    else $error("channel 1 compare without equal counter");

  // Bus answer lasts one cycle and an error only rides with it
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held for more than one cycle");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside the access phase");

  c_capture_seen: cover property (cap_ev[0] ##1 s.ctl[0].flag);
  c_flag_cleared: cover property (s.armed[1] ##[1:20] $fell(s.ctl[1].flag));
  c_buffer_swap: cover property (s.ctl[0].buf_sel && counter_wrap && s.buf_pend != s.buf_act);
  c_full_duty: cover property (s.full_act[0] && out_mode[0] && counter_wrap);
  c_compare_seen: cover property (cmp_ev[0] ##1 s.ctl[0].flag);

endmodule : tcc_timer_channel

// ==== bench/tcc_pin_model.sv ====
// External source that drives the two channel pins
`timescale 1ns/10ps
module tcc_pin_model (
  input wire logic pclk,
  input wire logic [1:0] level,
  output logic [1:0] pin_in
);
  // Pins start low so reset sees a known level
  initial pin_in = 2'h0;
  // A requested level lands one clock later and then holds; the bench
  // never moves a pin inside the settle window before capture is enabled
  always @(posedge pclk) begin
    pin_in <= level;
  end
endmodule : tcc_pin_model

// ==== bench/tcc_timer_channel_tb.sv ====
// Self-checking bench for the timer channel capture/compare block
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module tcc_timer_channel_tb;
  localparam logic [7:0] C0 = tcc_pkg::IDX_CTL[0];
  localparam logic [7:0] C1 = tcc_pkg::IDX_CTL[1];
  localparam logic [7:0] H0 = tcc_pkg::IDX_HI[0];
  localparam logic [7:0] L0 = tcc_pkg::IDX_LO[0];
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wrap = 1'b0, halt = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, slv, lvl;
  logic [15:0] cv = 16'h0000;
  logic [15:0] v;
  logic [1:0] req = 2'h0, pin_in, pin_out, pin_oe, chan_irq;
  logic [7:0] rd;
  int error_cnt = 0, tests_run = 0, seed = 13596;

  tcc_timer_channel DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counter_value(cv), .counter_wrap(wrap),
    .counter_halt(halt), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .chan_irq(chan_irq));
  tcc_pin_model PIN (.pclk(pclk), .level(req), .pin_in(pin_in));

  // 100 MHz bus clock
  always #5 pclk = ~pclk;

  // ****************************************
  // Bus and helper tasks
  // ****************************************
  // One APB transfer; waits on pready with a bound rather than a fixed count
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      $display("ERROR t=%0t no pready", $time);
    end
    rd = prdata[7:0];
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // Counter shows v for exactly one sampled cycle, optionally with a wrap
  task automatic hit(input logic w);
    cv <= v;
    wrap <= w;
    tick(1);
    cv <= ~v;
    wrap <= 1'b0;
    tick(3);
  endtask : hit

  task automatic report_and_stop;
    $display("tests=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    tick(8);
    presetn <= 1'b1;
    apb(0, C0, 8'h00);
    `CHK(rd, 8'h00)
    `CHK({pin_oe, chan_irq, pin_out}, 6'h03)
    apb(1, C0, 8'h80);
    apb(0, C0, 8'h00);
    `CHK(rd[7], 1'b0)
    apb(0, 8'h50, 8'h00);
    `CHK(slv, 1'b1)
    $display("test reset done");
    // Wrong edge first, then the active edge, for each single-edge capture code; the both-edges code sets on the first edge
    for (int e = 1; e < 4; e++) begin
      req[0] <= (e != 2);
      tick(4);
      apb(1, C0, {4'h4, e[1:0], 2'h0});
      v = $random(seed);
      cv <= v;
      req[0] <= (e == 2);
      tick(4);
      apb(0, C0, 8'h00);
      `CHK(rd[7], e == 3)
      if (e != 3) begin
        req[0] <= (e != 2);
        tick(4);
      end
      apb(0, C0, 8'h00);
      `CHK({rd[7], chan_irq[0]}, 2'h3)
      apb(0, H0, 8'h00);
      `CHK(rd, v[15:8])
      apb(0, L0, 8'h00);
      `CHK(rd, v[7:0])
      apb(1, C0, {4'h4, e[1:0], 2'h0});
      apb(0, C0, 8'h00);
      `CHK(rd[7], 1'b0)
    end
    halt <= 1'b1;
    req[0] <= ~req[0];
    tick(4);
    apb(0, C0, 8'h00);
    `CHK(rd[7], 1'b0)
    halt <= 1'b0;
    apb(0, H0, 8'h00);
    req[0] <= ~req[0];
    tick(4);
    apb(0, C0, 8'h00);
    `CHK(rd[7], 1'b0)
    apb(0, L0, 8'h00);
    req[0] <= ~req[0];
    tick(4);
    // Zero writes with no prior read of a set flag must not clear it
    apb(1, C0, 8'h4C);
    apb(1, C0, 8'h0C);
    tick(2);
    `CHK(chan_irq[0], 1'b0)
    apb(0, C0, 8'h00);
    `CHK(rd[7], 1'b1)
    $display("test capture done");
    halt <= 1'b1;
    apb(1, C0, 8'h10);
    tick(2);
    `CHK({pin_oe[0], pin_out[0]}, 2'h0)
    halt <= 1'b0;
    lvl = 1'b0;
    // Set, clear, then toggle on compare
    for (int e = 3; e > 0; e--) begin
      v = $random(seed);
      apb(1, H0, v[15:8]);
      apb(1, L0, v[7:0]);
      // Clear the old flag first so the match below must set it again
      apb(0, C0, 8'h00);
      apb(1, C0, {4'h1, e[1:0], 2'h0});
      hit(1'b0);
      lvl = (e == 3) ? 1'b1 : (e == 2) ? 1'b0 : ~lvl;
      `CHK({pin_oe[0], pin_out[0]}, {1'b1, lvl})
      apb(0, C0, 8'h00);
      `CHK(rd[7], 1'b1)
    end
    apb(1, C0, 8'h14);
    apb(1, H0, v[15:8]);
    hit(1'b0);
    `CHK(pin_out[0], lvl)
    apb(1, L0, v[7:0]);
    hit(1'b0);
    lvl = ~lvl;
    `CHK(pin_out[0], lvl)
    apb(1, C0, 8'h16);
    v = ~cv;
    hit(1'b1);
    lvl = ~lvl;
    `CHK(pin_out[0], lvl)
    apb(1, C0, 8'h1E);
    v = cv;
    v = ~v;
    apb(1, H0, v[15:8]);
    apb(1, L0, v[7:0]);
    hit(1'b1);
    lvl = ~lvl;
    `CHK(pin_out[0], lvl)
    $display("test compare done");
    apb(1, C1, 8'h18);
    tick(2);
    `CHK(pin_oe[1], 1'b1)
    apb(1, C0, 8'h24);
    tick(2);
    `CHK(pin_oe, 2'h1)
    apb(0, C1, 8'h00);
    `CHK(rd, 8'h00)
    $display("test buffer select done");
    report_and_stop();
  end
endmodule : tcc_timer_channel_tb
